// ==== hdl/lfs_pkg.sv ====
package lfs_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 25;       // Core clock, 40 ns period
  localparam int OTP_BLANK_US   = 180;      // Least OTP blanking at start
  localparam int BO_BLANK_MS    = 25;       // Brown-out persistence
  localparam int GND_OPEN_US    = 200;      // Ground-open persistence
  localparam int ZERO_SHORT_MS  = 90;       // Output short persistence
  localparam int AUTOREC_S      = 4;        // Auto-recovery pause
  localparam int OTP_BLANK_CYC  = OTP_BLANK_US * CLK_MHZ;
  localparam int BO_BLANK_CYC   = BO_BLANK_MS * 1000 * CLK_MHZ;
  localparam int GND_OPEN_CYC   = GND_OPEN_US * CLK_MHZ;
  localparam int ZERO_SHORT_CYC = ZERO_SHORT_MS * 1000 * CLK_MHZ;
  localparam int AUTOREC_CYC    = AUTOREC_S * 1000 * 1000 * CLK_MHZ;
  localparam logic [2:0] WIND_PERIODS = 3'h4; // Overshoot periods in a row
  localparam logic [8:0] FOLD_FULL    = 9'h100; // Depth code at stop level

  // ---------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_DIM    = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_SETPT  = 5'h0c;
  localparam logic [4:0] REG_CAUSE  = 5'h10;
  localparam logic [7:0] DIM_RST    = 8'hff;  // Full current, no dimming
  localparam logic       CTRL_RST   = 1'h1;   // Drive allowed
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // Fault cause bit positions
  localparam int C_VCC_OVP = 0;
  localparam int C_PROG    = 1;
  localparam int C_OTP     = 2;
  localparam int C_DIE     = 3;
  localparam int C_DIODE   = 4;
  localparam int C_WIND    = 5;
  localparam int C_ZERO    = 6;
  localparam int C_BO      = 7;
  localparam int C_CS      = 8;
  localparam int C_GND     = 9;
  localparam int NCAUSE    = 10;

  // Supervisor states
  typedef enum logic [2:0] {
    ST_LOCKOUT, ST_RUN, ST_AUTOREC, ST_BROWNOUT, ST_LATCHED
  } lfs_state_e;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic vcc_ovp;                  // Supply over-voltage
    logic programmable_overvoltage; // Shutdown pin above 2.5 V
    logic ntc_below_otp_off;        // Severe NTC over-temperature
    logic ntc_above_otp_on;         // NTC release level
    logic line_below_bo_off;        // Line sense under 0.9 V
    logic line_above_bo_on;         // Line sense over 1.0 V
    logic die_hot;                  // Die above about 150 C
    logic die_cool;                 // Die below about 100 C
    logic cs_low_impedance;         // Sense pin at or below 120 ohm
    logic gnd_open;                 // Sense pin diode conducting
    logic zero_short;               // Zero-crossing under short level
    logic cs_over_stop;             // Sense above 150 % of limit
    logic output_diode_short_flag;  // Output diode short detector
    logic vcc_on;                   // Supply above turn-on level
    logic vcc_below_off;            // Supply below turn-off level
    logic vcc_below_reset;          // Supply below reset level
  } lfs_flags_s;
endpackage

// ==== hdl/lfs_sync.sv ====
`timescale 1ns/1ps
module lfs_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ---------------------------------------------------------------
  // Two-stage synchroniser, one per flag bit
  // ---------------------------------------------------------------
  logic [W-1:0] meta;  // First stage, read by second stage only

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Comparators toggle freely, so settle before use
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else if (ce) begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule

// ==== hdl/lfs_supervisor.sv ====
`timescale 1ns/1ps
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int OTP_BLANK  = lfs_pkg::OTP_BLANK_CYC,
  parameter int BO_BLANK   = lfs_pkg::BO_BLANK_CYC,
  parameter int GND_OPEN   = lfs_pkg::GND_OPEN_CYC,
  parameter int ZERO_SHORT = lfs_pkg::ZERO_SHORT_CYC,
  parameter int AUTOREC    = lfs_pkg::AUTOREC_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire lfs_pkg::lfs_flags_s flags,
  input  wire logic               period_end,
  input  wire logic               max_ton_end,
  input  wire logic [8:0]         foldback_depth,
  output logic                    gate_enable,
  output logic [7:0]              setpoint_out,
  output logic                    supply_lockout_flag,
  output logic                    startup_consumption,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import lfs_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  lfs_flags_s        sf;            // Synchronised flags
  lfs_state_e        state;         // Supervisor state
  lfs_state_e        next_state;    // Next supervisor state
  logic              run_entry;     // First cycle of a start-up
  logic              otp_active;    // Severe NTC heat, with hysteresis
  logic              die_active;    // Die overheat, with hysteresis
  logic              winding_short_flag; // Overshoot run complete
  logic [2:0]        wind_cnt;      // Overshoot periods in a row
  logic [31:0]       blank_cnt;     // Time since supply turn-on
  logic              blank_done;    // OTP comparator usable
  logic [31:0]       ar_cnt;        // Auto-recovery pause timer
  logic              ar_done;       // Pause elapsed
  logic [2:0]        pc_in;         // Persistence inputs
  logic [2:0]        pc_done;       // Persistence reached
  logic [NCAUSE-1:0] ev;            // Fault events this cycle
  logic [NCAUSE-1:0] cause;         // Sticky fault causes
  logic              ctrl_en;       // Software drive enable
  logic [7:0]        dim_set;       // Pre-foldback setpoint
  logic [8:0]        depth_c;       // Clamped foldback depth
  logic [16:0]       fold_prod;     // Setpoint times depth
  logic              cs_short;      // Sense pin short seen
  logic              auto_fault;    // Any auto-recovery fault
  logic              aw_held;       // Write address taken
  logic              w_held;        // Write data taken
  logic [4:0]        aw_addr;       // Held write address
  logic [31:0]       w_data;        // Held write data
  logic [3:0]        w_strb;        // Held byte enables
  logic              wr_go;         // Both halves present
  logic              aw_ok;         // Write address mapped
  logic [15:0]       wmask;         // Byte lanes 0 and 1

  // ---------------------------------------------------------------
  // Flag synchroniser
  // ---------------------------------------------------------------
  lfs_sync #(.W($bits(lfs_flags_s))) lfs_sync_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (flags),
    .q       (sf)
  );

  // ---------------------------------------------------------------
  // Persistence timers
  // ---------------------------------------------------------------
  assign pc_in = {sf.line_below_bo_off, sf.zero_short, sf.gnd_open};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pers
      localparam int LIM = (i == 0) ? GND_OPEN : (i == 1) ? ZERO_SHORT : BO_BLANK;
      logic [31:0] cnt;  // Cycles the condition has held
      // A gap in the condition restarts the count
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt <= 32'h0;
        end else if (ce) begin
          if (!pc_in[i]) begin
            cnt <= 32'h0;
          end else if (cnt < LIM) begin
            cnt <= cnt + 32'h1;
          end
        end
      end
      assign pc_done[i] = (cnt >= LIM);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Start-up blanking and auto-recovery timers
  // ---------------------------------------------------------------
  // Blanking restarts each time the supply comes up from lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_cnt <= 32'h0;
    end else if (ce) begin
      if (state == ST_LOCKOUT) begin
        blank_cnt <= 32'h0;
      end else if (blank_cnt < OTP_BLANK) begin
        blank_cnt <= blank_cnt + 32'h1;
      end
    end
  end
  assign blank_done = (blank_cnt >= OTP_BLANK);

  // Pause counts only inside auto-recovery
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_cnt <= 32'h0;
    end else if (ce) begin
      if (state != ST_AUTOREC) begin
        ar_cnt <= 32'h0;
      end else if (ar_cnt < AUTOREC) begin
        ar_cnt <= ar_cnt + 32'h1;
      end
    end
  end
  assign ar_done = (ar_cnt >= AUTOREC);

  // ---------------------------------------------------------------
  // Hysteresis flags and overshoot counter
  // ---------------------------------------------------------------
  // Set wins so a fresh trip is never lost on release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_lockout_flag <= 1'b1;
      otp_active          <= 1'b0;
      die_active          <= 1'b0;
    end else if (ce) begin
      if (sf.vcc_below_off) begin
        supply_lockout_flag <= 1'b1;
      end else if (sf.vcc_on) begin
        supply_lockout_flag <= 1'b0;
      end
      if (sf.ntc_below_otp_off && blank_done) begin
        otp_active <= 1'b1;
      end else if (sf.ntc_above_otp_on) begin
        otp_active <= 1'b0;
      end
      if (sf.die_hot) begin
        die_active <= 1'b1;
      end else if (sf.die_cool) begin
        die_active <= 1'b0;
      end
    end
  end

  // Counts periods whose peak overshot; a clean one clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wind_cnt <= 3'h0;
    end else if (ce) begin
      if (state != ST_RUN) begin
        wind_cnt <= 3'h0;
      end else if (period_end) begin
        if (!sf.cs_over_stop) begin
          wind_cnt <= 3'h0;
        end else if (wind_cnt < WIND_PERIODS) begin
          wind_cnt <= wind_cnt + 3'h1;
        end
      end
    end
  end
  assign winding_short_flag = (wind_cnt == WIND_PERIODS);

  // ---------------------------------------------------------------
  // Fault events
  // ---------------------------------------------------------------
  assign cs_short = sf.cs_low_impedance && (run_entry || max_ton_end);

  always_comb begin
    ev            = '0;
    ev[C_VCC_OVP] = sf.vcc_ovp;
    ev[C_PROG]    = sf.programmable_overvoltage;
    ev[C_OTP]     = otp_active;
    ev[C_DIE]     = die_active;
    ev[C_DIODE]   = sf.output_diode_short_flag;
    ev[C_WIND]    = winding_short_flag;
    ev[C_ZERO]    = pc_done[1];
    ev[C_BO]      = pc_done[2];
    ev[C_CS]      = cs_short;
    ev[C_GND]     = pc_done[0];
  end
  assign auto_fault = |ev[C_ZERO:C_VCC_OVP];

  // ---------------------------------------------------------------
  // Supervisor state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_LOCKOUT: begin
        if (!supply_lockout_flag) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ev[C_CS] || ev[C_GND]) begin
          next_state = ST_LATCHED;
        end else if (ev[C_BO]) begin
          next_state = ST_BROWNOUT;
        end else if (auto_fault) begin
          next_state = ST_AUTOREC;
        end else if (supply_lockout_flag) begin
          next_state = ST_LOCKOUT;
        end
      end
      ST_AUTOREC: begin
        // Heat flags must also have released
        if (ar_done && sf.vcc_on && !otp_active && !die_active) begin
          next_state = ST_RUN;
        end
      end
      ST_BROWNOUT: begin
        // No supply cycling needed here
        if (sf.line_above_bo_on && sf.vcc_on) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (sf.vcc_below_reset) begin
          next_state = ST_LOCKOUT;
        end
      end
      default: next_state = ST_LOCKOUT;
    endcase
  end

  // State register and start-up marker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_LOCKOUT;
      run_entry <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      run_entry <= (next_state == ST_RUN) && (state != ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Drive outputs and foldback setpoint
  // ---------------------------------------------------------------
  assign depth_c   = (foldback_depth > FOLD_FULL) ? FOLD_FULL : foldback_depth;
  assign fold_prod = dim_set * depth_c;

  // Registered outputs; gate drops the cycle the state leaves run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_enable         <= 1'b0;
      startup_consumption <= 1'b0;
      setpoint_out        <= 8'h0;
    end else if (ce) begin
      gate_enable         <= (next_state == ST_RUN) && ctrl_en;
      startup_consumption <= (next_state == ST_BROWNOUT);
      setpoint_out        <= dim_set - fold_prod[16:9];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign aw_ok = (aw_addr == REG_CTRL) || (aw_addr == REG_DIM) ||
                 (aw_addr == REG_CAUSE);
  assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // Address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 5'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= CTRL_RST;
      dim_set <= DIM_RST;
    end else if (ce && wr_go) begin
      if (aw_addr == REG_CTRL && w_strb[0]) begin
        ctrl_en <= w_data[0];
      end
      if (aw_addr == REG_DIM && w_strb[0]) begin
        dim_set <= w_data[7:0];
      end
    end
  end

  // Sticky causes: write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= '0;
    end else if (ce) begin
      if (wr_go && aw_addr == REG_CAUSE) begin
        cause <= (cause & ~(w_data[NCAUSE-1:0] & wmask[NCAUSE-1:0])) | ev;
      end else begin
        cause <= cause | ev;
      end
    end
  end

  // Read path, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr[4:0])
          REG_CTRL:   s_axi_rdata <= {31'h0, ctrl_en};
          REG_DIM:    s_axi_rdata <= {24'h0, dim_set};
          REG_STATUS: s_axi_rdata <= {24'h0, otp_active, die_active,
                                      supply_lockout_flag, startup_consumption,
                                      gate_enable, state};
          REG_SETPT:  s_axi_rdata <= {24'h0, setpoint_out};
          REG_CAUSE:  s_axi_rdata <= {22'h0, cause};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_ovp;
    @(posedge aclk) disable iff (!aresetn)
    (ce && state == ST_RUN && sf.vcc_ovp && !cs_short && !pc_done[0] &&
     !pc_done[2]) |=> (state == ST_AUTOREC) ##1 !gate_enable;
  endproperty
  a_ovp: assert property (p_ovp) else $error("supply ovp missed");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
    (state != ST_RUN) |-> !gate_enable;
  endproperty
  a_gate: assert property (p_gate) else $error("gate on in off mode");

  property p_fold;
    @(posedge aclk) disable iff (!aresetn)
    (ce && foldback_depth >= FOLD_FULL)
      |=> setpoint_out == $past(dim_set) - ($past(dim_set) >> 1);
  endproperty
  a_fold: assert property (p_fold) else $error("foldback not half");

  property p_blank;
    @(posedge aclk) disable iff (!aresetn)
    $rose(otp_active) |-> $past(blank_done);
  endproperty
  a_blank: assert property (p_blank) else $error("otp during blanking");

  property p_bo;
    @(posedge aclk) disable iff (!aresetn)
    (ce && state == ST_BROWNOUT && sf.line_above_bo_on && sf.vcc_on)
      |=> state == ST_RUN;
  endproperty
  a_bo: assert property (p_bo) else $error("brown-out exit late");

  property p_lockout;
    @(posedge aclk) disable iff (!aresetn)
    (ce && sf.vcc_below_off) |=> supply_lockout_flag;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout flag not set");

  property p_ar;
    @(posedge aclk) disable iff (!aresetn)
    (state == ST_AUTOREC && !ar_done) |=> state == ST_AUTOREC;
  endproperty
  a_ar: assert property (p_ar) else $error("early recovery");

  property p_wind;
    @(posedge aclk) disable iff (!aresetn)
    (ce && state == ST_RUN && wind_cnt == 3'h3 && period_end && sf.cs_over_stop)
      |=> ##1 state != ST_RUN;
  endproperty
  a_wind: assert property (p_wind) else $error("winding short missed");

  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
    (state == ST_LATCHED && !sf.vcc_below_reset) |=> state == ST_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("latch released early");
endmodule

// ==== test/lfs_power_stage.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Gate driver stand-in: period ends every 4 cycles while driving
// ---------------------------------------------------------------
module lfs_power_stage (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic gate_enable,
  output logic      period_end,
  output logic      max_ton_end
);
  logic [1:0] phase; // Position within the switching period
  // Every pulse runs to the on-time limit, so sense checks recur
  always_ff @(posedge aclk) begin
    if (!aresetn || !gate_enable) begin
      phase <= 2'h0;
      period_end <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      period_end <= (phase == 2'h3);
    end
  end
  assign max_ton_end = period_end;
endmodule

// ==== test/lfs_supervisor_test.sv ====
`timescale 1ns/1ps
module lfs_supervisor_test;
  import lfs_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and fault table
  // ---------------------------------------------------------------
  localparam logic [15:0] BASE = 16'h1504; // Supply, line, NTC, die all good
  localparam logic [15:0] TG [8] = '{16'h8000, 16'h4000, 16'h3000, 16'h0300,
                                      16'h0008, 16'h0010, 16'h0020, 16'h0c00};
  localparam logic [2:0]  ST [8] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3};
  logic aclk, aresetn, ce, pe, mt, ge, lk, sc;
  logic [15:0] fv;
  logic [8:0] depth;
  logic [7:0] spt;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [3:0] ws;
  int bad_count, comparisons;
  lfs_supervisor #(.OTP_BLANK(20), .BO_BLANK(50), .GND_OPEN(30), .ZERO_SHORT(60),
    .AUTOREC(100)) lfs_supervisor_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .flags(lfs_flags_s'(fv)), .period_end(pe), .max_ton_end(mt), .foldback_depth(depth),
    .gate_enable(ge), .setpoint_out(spt), .supply_lockout_flag(lk),
    .startup_consumption(sc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lfs_power_stage lfs_power_stage_i (.aclk(aclk), .aresetn(aresetn), .gate_enable(ge),
    .period_end(pe), .max_ton_end(mt));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Bounded wait; a timeout ends the run as a failure
  task automatic hang(input int n);
    if (n >= 400) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hang(n);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hang(n);
    v = rdata;
    rready <= 1'b0;
    chk(rresp, er);
  endtask
  task automatic wait_gate(input logic v);
    int n;
    for (n = 0; n < 400 && ge !== v; n++) @(posedge aclk);
    hang(n);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {aresetn, fv, depth, awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, bad_count, comparisons} = '0;
    ce = 1'b1;
    ws = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(ge, 0);
    chk(lk, 1);
    rd(32'h0, 2'h0, d);
    chk(d[0], 1);
    rd(32'h4, 2'h0, d);
    chk(d[7:0], 8'hff);
    rd(32'h14, 2'h2, d);
    // Hot NTC from the start: blanked, then it trips
    fv <= BASE ^ 16'h3000;
    wait_gate(1'b1);
    repeat (10) @(posedge aclk);
    chk(ge, 1);
    wait_gate(1'b0);
    chk(lk, 0);
    fv <= BASE;
    wait_gate(1'b1);
    wr(32'h4, 32'h80, 2'h0);
    depth <= 9'h100;
    rd(32'hc, 2'h0, d);
    chk(d[7:0], 8'h40);
    chk(spt, 8'h40);
    // Lane 0 disabled: the dimmed level must not move
    ws <= 4'h0;
    wr(32'h4, 32'h33, 2'h0);
    ws <= 4'hf;
    rd(32'hc, 2'h0, d);
    chk(d[7:0], 8'h40);
    // Enable low freezes all state, faults included
    ce <= 1'b0;
    fv <= BASE ^ 16'h8000;
    repeat (8) @(posedge aclk);
    chk(ge, 1);
    ce <= 1'b1;
    fv <= BASE;
    wr(32'h0, 32'h0, 2'h0);
    wait_gate(1'b0);
    wr(32'h0, 32'h1, 2'h0);
    wait_gate(1'b1);
    wr(32'h8, 32'h0, 2'h2);
    for (int i = 0; i < 8; i++) begin
      fv <= BASE ^ TG[i];
      wait_gate(1'b0);
      rd(32'h8, 2'h0, d);
      chk(d[2:0], ST[i]);
      chk(sc, ST[i] == 3'h3);
      fv <= BASE;
      wait_gate(1'b1);
    end
    rd(32'h10, 2'h0, d);
    chk(d[7:0], 8'hff);
    wr(32'h10, 32'h3ff, 2'h0);
    rd(32'h10, 2'h0, d);
    chk(d[9:0], 10'h0);
    // Sense short, then ground open: both latch until supply reset
    for (int j = 0; j < 2; j++) begin
      fv <= BASE | (j == 0 ? 16'h0080 : 16'h0040);
      wait_gate(1'b0);
      rd(32'h8, 2'h0, d);
      chk(d[2:0], 3'h4);
      fv <= 16'h1503;
      rd(32'h8, 2'h0, d);
      rd(32'h8, 2'h0, d);
      chk(d[2:0], 3'h0);
      chk(lk, 1);
      fv <= BASE;
      wait_gate(1'b1);
    end
    rd(32'h10, 2'h0, d);
    chk(d[9:0], 10'h300);
    tally_and_finish();
  end
endmodule
